// [bench/core_model.sv]
// Behavioural model of the core units that feed the status bank
`timescale 1ns/100ps
module core_model (
   input wire logic sys_clk,
   input wire logic early_loop_exit,
   output logic [1:0] acc_ovf_in,
   output logic [1:0] acc_clip_evt,
   output logic do_active,
   output logic rep_active,
   output logic [2:0] do_depth,
   output logic alu_upd,
   output logic [7:0] alu_bits,
   output logic prio_load,
   output logic [3:0] prio_new,
   output logic nesting_disable
);
   // Idle core until the bench asks for activity
   initial begin
      {acc_ovf_in, acc_clip_evt, do_active, rep_active, do_depth} = '0;
      {alu_upd, alu_bits, prio_load, prio_new, nesting_disable} = '0;
   end
   // Early exit ends the innermost loop at the first clock edge where it is seen high
   always @(posedge sys_clk) begin
      if (early_loop_exit === 1'b1 && do_depth != 3'h0) begin
         do_depth <= do_depth - 3'h1;
         do_active <= (do_depth != 3'h1);
      end
   end
   // Level inputs change just after an edge and then hold
   task levels(input logic [1:0] ovf, input logic [2:0] depth, input logic rep,
               input logic nest);
      @(posedge sys_clk);
      acc_ovf_in <= ovf;
      do_depth <= depth;
      do_active <= (depth != 3'h0);
      rep_active <= rep;
      nesting_disable <= nest;
   endtask
   // Saturation, flag loads and priority loads are one-cycle pulses
   task pulse(input logic [1:0] clip, input logic upd, input logic [7:0] bits,
              input logic pl, input logic [3:0] pr);
      @(posedge sys_clk);
      acc_clip_evt <= clip;
      alu_upd <= upd;
      alu_bits <= bits;
      prio_load <= pl;
      prio_new <= pr;
      @(posedge sys_clk);
      acc_clip_evt <= 2'b00;
      alu_upd <= 1'b0;
      prio_load <= 1'b0;
   endtask
endmodule

// [bench/cpu_status_core_control_tb.sv]
// Self-checking bench for the status flags and core control bank
`timescale 1ns/100ps
module cpu_status_core_control_tb;
   import cpu_status_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [DATA_W-1:0] avs_readdata, rdata;
   logic avs_waitrequest, do_active, rep_active, alu_upd, prio_load, nesting_disable;
   logic user_irq_disable, early_loop_exit, dsp_mul_unsigned, acc_a_clip_en, acc_b_clip_en;
   logic store_clip_en, clip_width_sel, prog_window_en, rounding_sel, dsp_int_mode;
   logic [1:0] acc_ovf_in, acc_clip_evt, acc_clip_sticky;
   logic [2:0] do_depth;
   logic [3:0] prio_new, cpu_priority;
   logic [7:0] alu_bits;
   int fail_count = 0;
   int comparisons = 0;
   int pos [8] = '{12, 7, 6, 5, 4, 2, 1, 0};
   wire [7:0] ctl_outs = {dsp_mul_unsigned, acc_a_clip_en, acc_b_clip_en, store_clip_en,
                          clip_width_sel, prog_window_en, rounding_sel, dsp_int_mode};
   wire [4:0] prio_outs = {user_irq_disable, cpu_priority};

   // 100 MHz core clock
   always #5 sys_clk = ~sys_clk;

   cpu_status_core_control u_cpu_status_core_control (
      .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_ovf_in(acc_ovf_in),
      .acc_clip_evt(acc_clip_evt), .do_active(do_active), .rep_active(rep_active),
      .do_depth(do_depth), .alu_upd(alu_upd), .alu_byte(alu_bits[7]), .alu_sub(alu_bits[6]),
      .alu_nib_cout(alu_bits[5]), .alu_byte_cout(alu_bits[4]), .alu_msb_cout(alu_bits[3]),
      .alu_neg(alu_bits[2]), .alu_sovf(alu_bits[1]), .alu_zero(alu_bits[0]),
      .prio_load(prio_load), .prio_new(prio_new), .nesting_disable(nesting_disable),
      .cpu_priority(cpu_priority), .user_irq_disable(user_irq_disable),
      .early_loop_exit(early_loop_exit), .acc_clip_sticky(acc_clip_sticky),
      .dsp_mul_unsigned(dsp_mul_unsigned), .acc_a_clip_en(acc_a_clip_en),
      .acc_b_clip_en(acc_b_clip_en), .store_clip_en(store_clip_en),
      .clip_width_sel(clip_width_sel), .prog_window_en(prog_window_en),
      .rounding_sel(rounding_sel), .dsp_int_mode(dsp_int_mode));

   core_model u_core_model (
      .sys_clk(sys_clk), .early_loop_exit(early_loop_exit), .acc_ovf_in(acc_ovf_in),
      .acc_clip_evt(acc_clip_evt), .do_active(do_active), .rep_active(rep_active),
      .do_depth(do_depth), .alu_upd(alu_upd), .alu_bits(alu_bits), .prio_load(prio_load),
      .prio_new(prio_new), .nesting_disable(nesting_disable));

   // Compare and count; four-state equality so an unknown matches only an unknown
   task check_eq(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task test_done();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One access, held until waitrequest is sampled low; the watchdog bounds the wait
   task bus(input logic wr, input logic [3:0] addr, input logic [15:0] data,
            input logic [3:0] be);
      @(posedge sys_clk);
      avs_address <= addr;
      avs_writedata <= {16'h0000, data};
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge sys_clk);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task rd(input logic [3:0] addr, input logic [15:0] exp);
      bus(1'b0, addr, 16'h0000, 4'hf);
      check_eq(rdata, {16'h0000, exp});
   endtask

   initial begin
      // Falling edge at time zero so no flop meets the first clock unknown
      rst_b <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      // Reset values, then a write into the unmapped hole
      rd(FLAGS_OFF, 16'h0000);
      rd(CTRL_OFF, 16'h0020);
      bus(1'b1, 4'h8, 16'hffff, 4'hf);
      rd(4'h8, 16'h0000);
      rd(CTRL_OFF, 16'h0020);
      // Overflow flags follow the accumulators
      u_core_model.levels(2'b01, 3'h0, 1'b0, 1'b0);
      rd(FLAGS_OFF, 16'h8800);
      u_core_model.levels(2'b10, 3'h0, 1'b0, 1'b0);
      rd(FLAGS_OFF, 16'h4800);
      u_core_model.levels(2'b00, 3'h0, 1'b0, 1'b0);
      rd(FLAGS_OFF, 16'h0000);
      // Sticky saturation: writing ones never sets, zeros clear
      u_core_model.pulse(2'b01, 1'b0, 8'h00, 1'b0, 4'h0);
      rd(FLAGS_OFF, 16'h2400);
      bus(1'b1, FLAGS_OFF, 16'hfeff, 4'h2);
      rd(FLAGS_OFF, 16'h2400);
      u_core_model.pulse(2'b10, 1'b0, 8'h00, 1'b0, 4'h0);
      #1;
      check_eq({30'h0, acc_clip_sticky}, 32'h3);
      bus(1'b1, FLAGS_OFF, 16'h1400, 4'h2);
      rd(FLAGS_OFF, 16'h1400);
      u_core_model.pulse(2'b01, 1'b0, 8'h00, 1'b0, 4'h0);
      bus(1'b1, FLAGS_OFF, 16'h3000, 4'h2);
      rd(FLAGS_OFF, 16'h0000);
      // Deepest nesting, then an early exit drops one level
      u_core_model.levels(2'b00, 3'h7, 1'b1, 1'b0);
      rd(FLAGS_OFF, 16'h0210);
      rd(CTRL_OFF, 16'h0720);
      bus(1'b1, CTRL_OFF, 16'h0820, 4'h3);
      #1;
      check_eq({31'h0, early_loop_exit}, 32'h1);
      @(posedge sys_clk);
      #1;
      check_eq({31'h0, early_loop_exit}, 32'h0);
      rd(CTRL_OFF, 16'h0620);
      u_core_model.levels(2'b00, 3'h0, 1'b0, 1'b0);
      rd(FLAGS_OFF, 16'h0000);
      // ALU loads: byte ops take half carry from bit 3, word ops from bit 7
      for (int i = 0; i < 8; i++) begin
         u_core_model.pulse(2'b00, 1'b1, {i[0], i[0], i[1], ~i[1], i[2], i[1] ^ i[2], i[0],
                            ~i[2]}, 1'b0, 4'h0);
         rd(FLAGS_OFF, {7'h0, i[0] ? i[1] : ~i[1], 4'h0, i[1] ^ i[2], i[0], ~i[2], i[2]});
      end
      bus(1'b1, FLAGS_OFF, 16'h010f, 4'h3);
      rd(FLAGS_OFF, 16'h010f);
      // Priority field, its lock, and the clear-only msb
      bus(1'b1, FLAGS_OFF, 16'h00f0, 4'h3);
      rd(FLAGS_OFF, 16'h00e0);
      check_eq({27'h0, prio_outs}, 32'h17);
      u_core_model.levels(2'b00, 3'h0, 1'b0, 1'b1);
      bus(1'b1, FLAGS_OFF, 16'h0000, 4'h3);
      rd(FLAGS_OFF, 16'h00e0);
      u_core_model.levels(2'b00, 3'h0, 1'b0, 1'b0);
      u_core_model.pulse(2'b00, 1'b0, 8'h00, 1'b1, 4'ha);
      rd(FLAGS_OFF, 16'h0040);
      rd(CTRL_OFF, 16'h0028);
      check_eq({27'h0, prio_outs}, 32'h1a);
      bus(1'b1, CTRL_OFF, 16'h0020, 4'h3);
      rd(CTRL_OFF, 16'h0020);
      check_eq({27'h0, prio_outs}, 32'h02);
      bus(1'b1, CTRL_OFF, 16'h0028, 4'h3);
      rd(CTRL_OFF, 16'h0020);
      // Each writable control bit alone, unimplemented bits written high
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, CTRL_OFF, 16'he000 | (16'h0001 << pos[k]), 4'h3);
         rd(CTRL_OFF, 16'h0001 << pos[k]);
         check_eq({24'h0, ctl_outs}, {24'h0, 8'h80 >> k});
      end
      test_done();
   end

   // Watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      test_done();
   end
endmodule

// [rtl/cpu_status_core_control.sv]
// Status flags and core control register bank with an Avalon-MM slave
//
// Contract
// - Accumulator overflow flags follow accumulator state
// - Saturation events set sticky flags per accumulator
// - Software may clear sticky flags, never set
// - Bit 11 is OR of overflow flags
// - Bit 10 ORs sticky flags; clearing clears both
// - DO and REPEAT activity bits track loops
// - Half carry from bit 3 or 7
// - Priority level joins msb; 111 masks
// - Priority bits locked while nesting disabled
// - Negative flag follows result sign
// - Signed overflow flag on sign flip
// - Zero flag set by zero, cleared otherwise
// - Carry flag from msb, inverted borrow; the code takes alu_msb_cout uninverted on subtract too
// - Control bit 12 selects unsigned multiply
// - Write one ends DO loop; reads zero
// - Bits 10-8 report DO nesting depth
// - Saturation enables for A and B, reset off
// - Store saturation enable resets to one
// - Bit 4 picks 9.31 or 1.31 saturation
// - Priority msb is clear-only by software
// - Bit 2 opens program space window
// - Rounding select and integer mode bits
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
module cpu_status_core_control (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [cpu_status_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [cpu_status_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [cpu_status_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [1:0] acc_ovf_in,
   input wire logic [1:0] acc_clip_evt,
   input wire logic do_active,
   input wire logic rep_active,
   input wire logic [2:0] do_depth,
   input wire logic alu_upd,
   input wire logic alu_byte,
   input wire logic alu_sub,
   input wire logic alu_nib_cout,
   input wire logic alu_byte_cout,
   input wire logic alu_msb_cout,
   input wire logic alu_neg,
   input wire logic alu_sovf,
   input wire logic alu_zero,
   input wire logic prio_load,
   input wire logic [3:0] prio_new,
   input wire logic nesting_disable,
   output logic [3:0] cpu_priority,
   output logic user_irq_disable,
   output logic early_loop_exit,
   output logic [1:0] acc_clip_sticky,
   output logic dsp_mul_unsigned,
   output logic acc_a_clip_en,
   output logic acc_b_clip_en,
   output logic store_clip_en,
   output logic clip_width_sel,
   output logic prog_window_en,
   output logic rounding_sel,
   output logic dsp_int_mode
);
   import cpu_status_pkg::*;

   // Byte-lane merge, used for the control register
   function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0] old_v,
                                                    input logic [REG_W-1:0] new_v,
                                                    input logic [1:0] be);
      lane_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
   endfunction

   logic rst_s1_q;
   logic rst_n;
   logic wait_q;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0] acc_ovf_q;
   logic [1:0] sticky_q;
   logic [1:0] sticky_d;
   logic loop_q;
   logic repeat_q;
   logic [2:0] depth_q;
   logic half_carry_q;
   logic half_carry_d;
   logic [3:0] alu_flags_q;
   logic [3:0] alu_flags_d;
   logic [2:0] prio_lo_q;
   logic [2:0] prio_lo_d;
   logic prio_msb_q;
   logic prio_msb_d;
   logic irq_dis_q;
   logic exit_q;
   logic [REG_W-1:0] cfg_q;
   logic [REG_W-1:0] cfg_d;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // Bus decode: an access completes in the cycle where waitrequest is low
   wire req = avs_read | avs_write;
   wire accept = req & wait_q;
   wire done_wr = avs_write & ~wait_q;
   wire hit_flags = (avs_address == FLAGS_OFF);
   wire hit_ctrl = (avs_address == CTRL_OFF);
   wire [REG_W-1:0] wd = avs_writedata[REG_W-1:0];
   // Only lanes 0 and 1 carry register bits; upper lanes are ignored
   wire wr_flags_lo = done_wr & hit_flags & avs_byteenable[0];
   wire wr_flags_hi = done_wr & hit_flags & avs_byteenable[1];
   wire wr_ctrl_lo = done_wr & hit_ctrl & avs_byteenable[0];
   wire wr_ctrl_hi = done_wr & hit_ctrl & avs_byteenable[1];

   // One wait cycle per access keeps readdata registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~accept;
      end
   end

   // Combined views and readback words
   wire either_ovf = |acc_ovf_q;
   wire either_clip = |sticky_q;
   wire [REG_W-1:0] flags_rd = {acc_ovf_q[0], acc_ovf_q[1], sticky_q[0], sticky_q[1],
                                either_ovf, either_clip, loop_q, half_carry_q,
                                prio_lo_q, repeat_q, alu_flags_q};
   // Early-exit strobe and unimplemented bits read as zero
   wire [REG_W-1:0] ctrl_rd = {3'h0, cfg_q[POS_MUL_UNS], 1'b0, depth_q,
                               cfg_q[7:4], prio_msb_q, cfg_q[2:0]};
   wire [REG_W-1:0] rd_sel = hit_flags ? flags_rd : (hit_ctrl ? ctrl_rd : 16'h0000);

   // Read data is captured when the request is accepted; unmapped reads give zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
      end else if (accept && avs_read) begin
         rdata_q <= {16'h0000, rd_sel};
      end
   end

   // Accumulator overflow and loop activity mirror the core each cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ovf_q <= 2'b00;
         loop_q <= 1'b0;
         repeat_q <= 1'b0;
         depth_q <= DEPTH_RESET;
      end else begin
         acc_ovf_q <= acc_ovf_in;
         loop_q <= do_active;
         repeat_q <= rep_active;
         depth_q <= do_depth;
      end
   end

   // Sticky saturation flags: a saturation in the clearing cycle still sets
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sticky
         wire sw_clr = wr_flags_hi & (~wd[POS_A_CLIP - gi] | ~wd[POS_EITHER_CLIP]);
         assign sticky_d[gi] = acc_clip_evt[gi] | (sticky_q[gi] & ~sw_clr);
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               sticky_q[gi] <= 1'b0;
            end else begin
               sticky_q[gi] <= sticky_d[gi];
            end
         end
      end
   endgenerate

   // ALU flags: an ALU update wins over a software write in the same cycle
   wire alu_half = alu_byte ? alu_nib_cout : alu_byte_cout;
   wire alu_carry = alu_sub ? alu_msb_cout : alu_msb_cout;
   wire [3:0] alu_new = {alu_neg, alu_sovf, alu_zero, alu_carry};
   assign half_carry_d = alu_upd ? alu_half : (wr_flags_hi ? wd[POS_HALF_CARRY] : half_carry_q);
   assign alu_flags_d = alu_upd ? alu_new : (wr_flags_lo ? wd[3:0] : alu_flags_q);

   // Priority: arbitration loads win; software only while nesting is allowed
   wire sw_prio = wr_flags_lo & ~nesting_disable;
   assign prio_lo_d = prio_load ? prio_new[2:0] : (sw_prio ? wd[7:5] : prio_lo_q);
   // Msb may be cleared by software; only a hardware load sets it
   assign prio_msb_d = prio_load ? prio_new[3] :
                       (prio_msb_q & ~(wr_ctrl_lo & ~wd[POS_PRIO_MSB]));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_carry_q <= FLAGS_RESET[POS_HALF_CARRY];
         alu_flags_q <= FLAGS_RESET[3:0];
         prio_lo_q <= PRIO_RESET;
         prio_msb_q <= CTRL_RESET[POS_PRIO_MSB];
         irq_dis_q <= 1'b0;
      end else begin
         half_carry_q <= half_carry_d;
         alu_flags_q <= alu_flags_d;
         prio_lo_q <= prio_lo_d;
         prio_msb_q <= prio_msb_d;
         irq_dis_q <= (prio_lo_d == PRIO_ALL_MASKED) | prio_msb_d;
      end
   end

   // Configuration bits; depth, strobe and msb positions are not stored here
   wire [REG_W-1:0] cfg_wmask = 16'h10f7;
   wire [REG_W-1:0] cfg_merged = lane_merge(cfg_q, wd, {wr_ctrl_hi, wr_ctrl_lo});
   assign cfg_d = (cfg_merged & cfg_wmask) | (cfg_q & ~cfg_wmask);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CTRL_RESET;
         exit_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         exit_q <= wr_ctrl_hi & wd[POS_EARLY_EXIT];
      end
   end

   // Outputs straight from flops
   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;
   assign cpu_priority = {prio_msb_q, prio_lo_q};
   assign user_irq_disable = irq_dis_q;
   assign early_loop_exit = exit_q;
   assign acc_clip_sticky = sticky_q;
   assign dsp_mul_unsigned = cfg_q[POS_MUL_UNS];
   assign acc_a_clip_en = cfg_q[POS_A_CLIP_EN];
   assign acc_b_clip_en = cfg_q[POS_B_CLIP_EN];
   assign store_clip_en = cfg_q[POS_STORE_CLIP];
   assign clip_width_sel = cfg_q[POS_CLIP_WIDTH];
   assign prog_window_en = cfg_q[POS_PROG_WIN];
   assign rounding_sel = cfg_q[POS_ROUNDING];
   assign dsp_int_mode = cfg_q[POS_INT_MODE];

   // Checks on the bank's behaviour
   AST_OVF_TRACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (acc_ovf_q == $past(acc_ovf_in)))
      else $error("overflow flags do not follow accumulators");
   AST_STICKY_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      acc_clip_evt[0] |=> sticky_q[0] && flags_rd[POS_A_CLIP])
      else $error("saturation event lost");
   AST_SW_NO_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!sticky_q[1] && !acc_clip_evt[1]) |=> !sticky_q[1])
      else $error("sticky flag set without saturation");
   AST_EITHER_OVF: assert property (@(posedge sys_clk) disable iff (!rst_n)
      acc_ovf_in[1] |=> flags_rd[POS_EITHER_OVF])
      else $error("combined overflow missing");
   AST_COMBINED_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_flags_hi && !wd[POS_EITHER_CLIP] && acc_clip_evt == 2'b00) |=> !either_clip)
      else $error("combined clear left a sticky flag");
   AST_LOOP_BITS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (flags_rd[POS_LOOP_RUN] == $past(do_active)) &&
               (flags_rd[POS_REPEAT] == $past(rep_active)))
      else $error("loop activity bits wrong");
   AST_HALF_CARRY: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (alu_upd && alu_byte) |=> half_carry_q == $past(alu_nib_cout))
      else $error("byte half carry wrong");
   AST_ZERO_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
      alu_upd |=> alu_flags_q[POS_ZERO] == $past(alu_zero))
      else $error("zero flag wrong");
   AST_IRQ_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      user_irq_disable == ((cpu_priority[2:0] == PRIO_ALL_MASKED) || cpu_priority[3]))
      else $error("user interrupt mask wrong");
   AST_PRIO_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (nesting_disable && !prio_load) |=> prio_lo_q == $past(prio_lo_q))
      else $error("priority bits changed while locked");
   AST_EXIT_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_ctrl_hi && wd[POS_EARLY_EXIT]) |=> early_loop_exit ##1 !early_loop_exit)
      else $error("early exit strobe not one cycle");
   AST_MSB_NO_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!prio_msb_q && !prio_load) |=> !prio_msb_q)
      else $error("priority msb set by software");
   AST_STORE_CLIP_RST: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> store_clip_en && !acc_a_clip_en && !acc_b_clip_en)
      else $error("control reset value wrong");

   // Bus handshake: exactly one wait cycle, unmapped reads give zero
   // A second wait cycle would stall every core access, so it is checked here
   AST_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (req && avs_waitrequest) |=> !avs_waitrequest)
      else $error("access not answered after one wait cycle");
   AST_WAIT_RETURNS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (avs_read && avs_waitrequest && !hit_flags && !hit_ctrl) |=> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");

   // Accumulator views; a swapped bit or a broken OR shows up here
   AST_OVF_MAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (flags_rd[POS_A_OVF] == $past(acc_ovf_in[0])) &&
               (flags_rd[POS_B_OVF] == $past(acc_ovf_in[1])))
      else $error("overflow bits in wrong place");
   AST_EITHER_OVF_ANY: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> flags_rd[POS_EITHER_OVF] == ($past(acc_ovf_in) != 2'b00))
      else $error("combined overflow wrong");
   AST_STICKY_B_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      acc_clip_evt[1] |=> acc_clip_sticky[1] && flags_rd[POS_B_CLIP])
      else $error("saturation event on B lost");
   AST_STICKY_A_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (acc_clip_sticky[0] && !wr_flags_hi) |=> acc_clip_sticky[0])
      else $error("sticky A lost without a clear");
   AST_STICKY_B_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (acc_clip_sticky[1] && !wr_flags_hi) |=> acc_clip_sticky[1])
      else $error("sticky B lost without a clear");
   AST_STICKY_A_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_flags_hi && !wd[POS_A_CLIP] && !acc_clip_evt[0]) |=> !acc_clip_sticky[0])
      else $error("sticky A not cleared");

   // ALU flags come from the update that the core presents
   AST_NEG_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
      alu_upd |=> alu_flags_q[POS_NEG] == $past(alu_neg))
      else $error("negative flag wrong");
   AST_SOVF_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
      alu_upd |=> alu_flags_q[POS_SOVF] == $past(alu_sovf))
      else $error("signed overflow flag wrong");
   AST_CARRY_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
      alu_upd |=> alu_flags_q[POS_CARRY] == $past(alu_msb_cout))
      else $error("carry flag wrong");
   AST_WORD_HALF: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (alu_upd && !alu_byte) |=> half_carry_q == $past(alu_byte_cout))
      else $error("word half carry wrong");

   // Priority and loop state
   AST_PRIO_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      prio_load |=> cpu_priority == $past(prio_new))
      else $error("priority load lost");
   AST_PRIO_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_flags_lo && !nesting_disable && !prio_load) |=> cpu_priority[2:0] == $past(wd[7:5]))
      else $error("priority write lost while unlocked");
   AST_MSB_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_ctrl_lo && !wd[POS_PRIO_MSB] && !prio_load) |=> !cpu_priority[3])
      else $error("priority msb not cleared");
   AST_DEPTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> ctrl_rd[POS_DEPTH_LO +: 3] == $past(do_depth))
      else $error("nesting depth wrong");
   AST_EXIT_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(wr_ctrl_hi && wd[POS_EARLY_EXIT]) |=> !early_loop_exit)
      else $error("early exit without a request");

   // Control bits change only through a completed write
   AST_MUL_UNS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_ctrl_hi |=> dsp_mul_unsigned == $past(wd[POS_MUL_UNS]))
      else $error("multiply sign select wrong");
   AST_CLIP_CFG: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_ctrl_lo |=> ({acc_a_clip_en, acc_b_clip_en, store_clip_en, clip_width_sel} ==
                      $past(wd[7:4])))
      else $error("saturation controls wrong");
   AST_DSP_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_ctrl_lo |=> {prog_window_en, rounding_sel, dsp_int_mode} == $past(wd[2:0]))
      else $error("mode controls wrong");
   AST_CFG_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!wr_ctrl_lo && !wr_ctrl_hi) |=> $stable(cfg_q))
      else $error("control bits changed without a write");

   // Main scenarios
   COV_READ: cover property (@(posedge sys_clk) disable iff (!rst_n)
      avs_read && !avs_waitrequest && hit_flags);
   COV_STICKY_RACE: cover property (@(posedge sys_clk) disable iff (!rst_n)
      wr_flags_hi && !wd[POS_EITHER_CLIP] && acc_clip_evt[0]);
   COV_EXIT: cover property (@(posedge sys_clk) disable iff (!rst_n) early_loop_exit);
   COV_MASKED: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(user_irq_disable));
   COV_LOCKED_WRITE: cover property (@(posedge sys_clk) disable iff (!rst_n)
      wr_flags_lo && nesting_disable);
endmodule

// [rtl/cpu_status_pkg.sv]
// Constants shared by the status flags and core control register bank
package cpu_status_pkg;
   // Register map: byte addresses on the Avalon-MM slave
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] FLAGS_OFF = 4'h0;
   localparam logic [ADDR_W-1:0] CTRL_OFF = 4'h4;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;

   // Status flags register field positions
   localparam int POS_A_OVF = 15;
   localparam int POS_B_OVF = 14;
   localparam int POS_A_CLIP = 13;
   localparam int POS_B_CLIP = 12;
   localparam int POS_EITHER_OVF = 11;
   localparam int POS_EITHER_CLIP = 10;
   localparam int POS_LOOP_RUN = 9;
   localparam int POS_HALF_CARRY = 8;
   localparam int POS_PRIO_LO = 5;
   localparam int POS_REPEAT = 4;
   localparam int POS_NEG = 3;
   localparam int POS_SOVF = 2;
   localparam int POS_ZERO = 1;
   localparam int POS_CARRY = 0;

   // Core control register field positions
   localparam int POS_MUL_UNS = 12;
   localparam int POS_EARLY_EXIT = 11;
   localparam int POS_DEPTH_LO = 8;
   localparam int POS_A_CLIP_EN = 7;
   localparam int POS_B_CLIP_EN = 6;
   localparam int POS_STORE_CLIP = 5;
   localparam int POS_CLIP_WIDTH = 4;
   localparam int POS_PRIO_MSB = 3;
   localparam int POS_PROG_WIN = 2;
   localparam int POS_ROUNDING = 1;
   localparam int POS_INT_MODE = 0;

   // Reset values and field constants
   localparam logic [REG_W-1:0] FLAGS_RESET = 16'h0000;
   localparam logic [REG_W-1:0] CTRL_RESET = 16'h0020;
   localparam logic [2:0] PRIO_ALL_MASKED = 3'h7;
   localparam logic [2:0] PRIO_RESET = 3'h0;
   localparam logic [2:0] DEPTH_RESET = 3'h0;
endpackage
